// File: logic/cmp_timer_pkg.sv
package cmp_timer_pkg;

   // Register map: the block holds one control register.
   localparam int             ADDR_W         = 4;
   localparam logic [3:0]     CTRL_OFFSET    = 4'h0;

   // Bit positions inside the control register.
   localparam int             BIT_MIRROR_A   = 7;
   localparam int             BIT_MIRROR_B   = 6;
   localparam int             BIT_UNUSED     = 5;
   localparam int             BIT_ALT_CLK    = 4;
   localparam int             BIT_HYS_A      = 3;
   localparam int             BIT_HYS_B      = 2;
   localparam int             BIT_GATE_SEL   = 1;
   localparam int             BIT_SYNC_EN    = 0;

   // Reset value of the control register: gate pin selected, all else clear.
   localparam logic [7:0]     CTRL_RESET     = 8'h02;

   // Instruction clock runs at one quarter of the system clock.
   localparam int             INSTR_DIV      = 4;
   localparam logic [1:0]     DIV_RISE_PHASE = 2'h0;
   localparam logic [1:0]     DIV_FALL_PHASE = 2'h2;

   // Prescaler ratio is 2**sel with sel in 0..3.
   localparam int             PRE_W          = 3;
   localparam int             PRE_SEL_W      = 2;

   // Writable control fields, kept together as one carrier.
   typedef struct packed {
      logic timer_alt_clock_sel;
      logic cmp_a_hysteresis_en;
      logic cmp_b_hysteresis_en;
      logic timer_gate_source_sel;
      logic cmp_b_sync_en;
   } ctrl_t;

   // Synchronised view of the asynchronous inputs.
   typedef struct packed {
      logic ext_gate_pin;
      logic cmp_b_result;
      logic cmp_a_result;
   } async_in_t;

endpackage

// File: logic/input_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for a group of asynchronous levels.
module input_sync
   import cmp_timer_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_r;

   // The first stage feeds only the second stage, so metastability has a full cycle to settle.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_r <= '0;
         sync_out <= '0;
      end else begin
         stage1_r <= async_in;
         sync_out <= stage1_r;
      end
   end

endmodule

// File: logic/cmp_timer_gate_ctrl.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
// Overview of operation
// - Gate select 0 makes the second comparator output the timer gate.
// - Comparator gating acts only while the timer is on and gating is enabled.
// - Sync enabled captures comparator output on timer clock falling edges; otherwise passes through.
// - With a prescaler, the capture is clocked by the prescaler output.
// - Timer increments on rising edges, opposite to the falling-edge capture.
// - Two read-only bits mirror both comparator outputs in one read.
// - Reading the mirror bits leaves the comparator mismatch state untouched.
// - Alternate clock select 1 picks system clock, 0 picks quarter-rate instruction clock.
// - Two writable bits enable hysteresis for each comparator independently.
module cmp_timer_gate_ctrl
   import cmp_timer_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [ADDR_W-1:0]    addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic      [7:0]           rdata,
   input  wire logic                 cmp_a_result,
   input  wire logic                 cmp_b_result,
   input  wire logic                 ext_gate_pin,
   input  wire logic                 timer_on,
   input  wire logic                 timer_gate_en,
   input  wire logic [PRE_SEL_W-1:0] prescale_sel,
   output logic                      cmp_a_hysteresis_en,
   output logic                      cmp_b_hysteresis_en,
   output logic                      timer_gate,
   output logic                      timer_inc,
   output logic                      cmp_b_gate_level
);

   ctrl_t               ctrl_r;
   async_in_t           raw_in;
   async_in_t           sync_in;
   logic [1:0]          div_r;
   logic [PRE_W-1:0]    pre_cnt_r;
   logic [PRE_W-1:0]    pre_limit;
   logic                tclk_rise;
   logic                tclk_fall;
   logic                pre_rise;
   logic                pre_fall;
   logic                cmp_b_latch_r;
   logic                cmp_b_eff;
   logic                gate_src;
   logic                count_ok;
   logic                ctrl_hit;
   logic [7:0]          rdata_r;
   logic                timer_gate_r;
   logic                timer_inc_r;
   logic                cmp_b_level_r;

   assign ctrl_hit = (addr == CTRL_OFFSET);

   // Pins and comparator outputs come from outside the clock domain.
   assign raw_in.ext_gate_pin = ext_gate_pin;
   assign raw_in.cmp_b_result = cmp_b_result;
   assign raw_in.cmp_a_result = cmp_a_result;

   input_sync #(
      .WIDTH    ($bits(async_in_t))
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (raw_in),
      .sync_out (sync_in)
   );

   // Control register; bit 5 and the mirror bits have no storage, so writes to them vanish.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r.timer_alt_clock_sel   <= CTRL_RESET[BIT_ALT_CLK];
         ctrl_r.cmp_a_hysteresis_en   <= CTRL_RESET[BIT_HYS_A];
         ctrl_r.cmp_b_hysteresis_en   <= CTRL_RESET[BIT_HYS_B];
         ctrl_r.timer_gate_source_sel <= CTRL_RESET[BIT_GATE_SEL];
         ctrl_r.cmp_b_sync_en         <= CTRL_RESET[BIT_SYNC_EN];
      end else if (wr && ctrl_hit) begin
         ctrl_r.timer_alt_clock_sel   <= wdata[BIT_ALT_CLK];
         ctrl_r.cmp_a_hysteresis_en   <= wdata[BIT_HYS_A];
         ctrl_r.cmp_b_hysteresis_en   <= wdata[BIT_HYS_B];
         ctrl_r.timer_gate_source_sel <= wdata[BIT_GATE_SEL];
         ctrl_r.cmp_b_sync_en         <= wdata[BIT_SYNC_EN];
      end
   end

   // Hysteresis enables go straight from the register flops to the analog side.
   assign cmp_a_hysteresis_en = ctrl_r.cmp_a_hysteresis_en;
   assign cmp_b_hysteresis_en = ctrl_r.cmp_b_hysteresis_en;

   // Read port; a read has no side effect, which is why no mismatch clear leaves this block.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else if (rd && ctrl_hit) begin
         rdata_r[BIT_MIRROR_A] <= sync_in.cmp_a_result;
         rdata_r[BIT_MIRROR_B] <= sync_in.cmp_b_result;
         rdata_r[BIT_UNUSED]   <= 1'b0;
         rdata_r[BIT_ALT_CLK]  <= ctrl_r.timer_alt_clock_sel;
         rdata_r[BIT_HYS_A]    <= ctrl_r.cmp_a_hysteresis_en;
         rdata_r[BIT_HYS_B]    <= ctrl_r.cmp_b_hysteresis_en;
         rdata_r[BIT_GATE_SEL] <= ctrl_r.timer_gate_source_sel;
         rdata_r[BIT_SYNC_EN]  <= ctrl_r.cmp_b_sync_en;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign rdata = rdata_r;

   // Divider for the instruction clock; it free-runs so phase never depends on register writes.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   // Timer clock edges as enables; at full rate both edges fall in every cycle.
   always_comb begin
      if (ctrl_r.timer_alt_clock_sel) begin
         tclk_rise = 1'b1;
         tclk_fall = 1'b1;
      end else begin
         tclk_rise = (div_r == DIV_RISE_PHASE);
         tclk_fall = (div_r == DIV_FALL_PHASE);
      end
   end

   // Prescaler counts timer clock rising edges and wraps at the selected ratio.
   assign pre_limit = PRE_W'((1 << prescale_sel) - 1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_r <= '0;
      end else if (tclk_rise) begin
         if (pre_cnt_r >= pre_limit) begin
            pre_cnt_r <= '0;
         end else begin
            pre_cnt_r <= pre_cnt_r + PRE_W'(1);
         end
      end
   end

   // The prescaled clock falls on the first timer clock fall after its rise.
   assign pre_rise = tclk_rise && (pre_cnt_r >= pre_limit);
   assign pre_fall = tclk_fall && (pre_cnt_r == '0);

   // Falling-edge capture keeps the gate stable across the rising edge that counts.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_b_latch_r <= 1'b0;
      end else if (pre_fall) begin
         cmp_b_latch_r <= sync_in.cmp_b_result;
      end
   end

   // Unsynchronised mode passes the comparator straight on, at the risk of a missed count.
   assign cmp_b_eff = ctrl_r.cmp_b_sync_en ? cmp_b_latch_r : sync_in.cmp_b_result;

   // Gate source selection between comparator and the external pin.
   assign gate_src = ctrl_r.timer_gate_source_sel ? sync_in.ext_gate_pin
                                                  : cmp_b_eff;

   // Gating only restrains a running timer whose gate function is enabled.
   assign count_ok = timer_on && (!timer_gate_en || gate_src);

   // Registered outputs toward the timer.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_gate_r  <= 1'b0;
         timer_inc_r   <= 1'b0;
         cmp_b_level_r <= 1'b0;
      end else begin
         timer_gate_r  <= gate_src;
         timer_inc_r   <= pre_rise && count_ok;
         cmp_b_level_r <= cmp_b_eff;
      end
   end

   assign timer_gate       = timer_gate_r;
   assign timer_inc        = timer_inc_r;
   assign cmp_b_gate_level = cmp_b_level_r;

   // Checks on the control path.
   property p_ctrl_write;
      @(posedge clk) disable iff (!rst_n)
      wr && ctrl_hit |=> ctrl_r == $past(wdata[4:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

   property p_unused_zero;
      @(posedge clk) disable iff (!rst_n)
      rd |=> rdata_r[BIT_UNUSED] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bit read nonzero");

   property p_mirror;
      @(posedge clk) disable iff (!rst_n)
      rd && ctrl_hit |=> rdata_r[7:6] == $past({sync_in.cmp_a_result, sync_in.cmp_b_result});
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror bits wrong");

   property p_read_quiet;
      @(posedge clk) disable iff (!rst_n)
      rd && !wr |=> $stable(ctrl_r);
   endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("read changed control state");

   property p_timer_off;
      @(posedge clk) disable iff (!rst_n)
      !timer_on |=> !timer_inc_r;
   endproperty
   a_timer_off: assert property (p_timer_off) else $error("count while timer off");

   property p_pin_gate;
      @(posedge clk) disable iff (!rst_n)
      ctrl_r.timer_gate_source_sel && timer_on && timer_gate_en && pre_rise
      |=> timer_inc_r == $past(sync_in.ext_gate_pin);
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin gate not honoured");

   property p_cmp_gate;
      @(posedge clk) disable iff (!rst_n)
      !ctrl_r.timer_gate_source_sel && !ctrl_r.cmp_b_sync_en && timer_on && timer_gate_en && pre_rise
      |=> timer_inc_r == $past(sync_in.cmp_b_result);
   endproperty
   a_cmp_gate: assert property (p_cmp_gate) else $error("comparator gate not honoured");

   property p_latch_fall;
      @(posedge clk) disable iff (!rst_n)
      pre_fall |=> cmp_b_latch_r == $past(sync_in.cmp_b_result);
   endproperty
   a_latch_fall: assert property (p_latch_fall) else $error("capture missed fall");

   property p_latch_hold;
      @(posedge clk) disable iff (!rst_n)
      !pre_fall |=> $stable(cmp_b_latch_r);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("capture outside fall");

   property p_quarter_rate;
      @(posedge clk) disable iff (!rst_n)
      tclk_rise && !ctrl_r.timer_alt_clock_sel ##1 !ctrl_r.timer_alt_clock_sel [*3]
      |-> $past(tclk_fall, 1) && !$past(tclk_rise, 2) && !tclk_rise;
   endproperty
   a_quarter_rate: assert property (p_quarter_rate) else $error("instruction clock phase wrong");

   property p_inc_on_rise;
      @(posedge clk) disable iff (!rst_n)
      timer_inc_r |-> $past(pre_rise);
   endproperty
   a_inc_on_rise: assert property (p_inc_on_rise) else $error("count off rising edge");

   // Checks on the register side effects and the gate path; a stale read byte would alias a real status.
   property p_rdata_idle;
      @(posedge clk) disable iff (!rst_n)
      !(rd && ctrl_hit) |=> rdata_r == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

   property p_hys_write;
      @(posedge clk) disable iff (!rst_n)
      wr && ctrl_hit |=> {cmp_a_hysteresis_en, cmp_b_hysteresis_en} == $past(wdata[BIT_HYS_A:BIT_HYS_B]);
   endproperty
   a_hys_write: assert property (p_hys_write) else $error("hysteresis enables not written");

   property p_unmapped_write;
      @(posedge clk) disable iff (!rst_n)
      wr && !ctrl_hit |=> $stable(ctrl_r);
   endproperty
   a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed control");

   property p_pin_follow;
      @(posedge clk) disable iff (!rst_n)
      ctrl_r.timer_gate_source_sel |=> timer_gate_r == $past(sync_in.ext_gate_pin);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("gate does not follow pin");

   property p_sync_gate;
      @(posedge clk) disable iff (!rst_n)
      !ctrl_r.timer_gate_source_sel && ctrl_r.cmp_b_sync_en |=> timer_gate_r == $past(cmp_b_latch_r);
   endproperty
   a_sync_gate: assert property (p_sync_gate) else $error("gate does not follow captured level");

   property p_alt_full_rate;
      @(posedge clk) disable iff (!rst_n)
      ctrl_r.timer_alt_clock_sel |-> tclk_rise && tclk_fall;
   endproperty
   a_alt_full_rate: assert property (p_alt_full_rate) else $error("system clock rate not selected");

   // Main scenarios worth seeing.
   c_cmp_count:  cover property (@(posedge clk) disable iff (!rst_n)
                                 !ctrl_r.timer_gate_source_sel && timer_gate_en && timer_inc_r);
   c_pin_count:  cover property (@(posedge clk) disable iff (!rst_n)
                                 ctrl_r.timer_gate_source_sel && timer_gate_en && timer_inc_r);
   c_sync_cap:   cover property (@(posedge clk) disable iff (!rst_n)
                                 ctrl_r.cmp_b_sync_en && pre_fall && (prescale_sel != 2'h0));
   c_mirror_rd:  cover property (@(posedge clk) disable iff (!rst_n)
                                 rd && ctrl_hit && sync_in.cmp_a_result && sync_in.cmp_b_result);

endmodule

// File: testbench/timer_model.sv
`timescale 1ns/10ps
// Far-side timer: it owns run, gate enable and prescale, and counts increments.
module timer_model
   import cmp_timer_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 timer_inc,
   input  wire logic                 on_req,
   input  wire logic                 gate_en_req,
   input  wire logic [PRE_SEL_W-1:0] sel_req,
   output logic                      timer_on,
   output logic                      timer_gate_en,
   output logic      [PRE_SEL_W-1:0] prescale_sel,
   output logic      [15:0]          count_r
);
   // Controls are registered so that they only move just after a rising edge.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_on      <= 1'b0;
         timer_gate_en <= 1'b0;
         prescale_sel  <= 2'h0;
      end else begin
         timer_on      <= on_req;
         timer_gate_en <= gate_en_req;
         prescale_sel  <= sel_req;
      end
   end

   // The count moves on the rising edge, away from the falling-edge capture.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 16'h0000;
      end else if (timer_inc) begin
         count_r <= count_r + 16'h0001;
      end
   end
endmodule

// File: testbench/tb_comparator_timer_gate_sync_ctrl.sv
`timescale 1ns/10ps
module tb_comparator_timer_gate_sync_ctrl;
   import cmp_timer_pkg::*;
   logic                 clk;
   logic                 rst_n;
   logic [ADDR_W-1:0]    addr;
   logic [7:0]           wdata;
   logic                 wr;
   logic                 rd;
   logic [7:0]           rdata;
   logic                 cmp_a_result;
   logic                 cmp_b_result;
   logic                 ext_gate_pin;
   logic                 on_req;
   logic                 gen_req;
   logic [PRE_SEL_W-1:0] sel_req;
   logic                 timer_on;
   logic                 timer_gate_en;
   logic [PRE_SEL_W-1:0] prescale_sel;
   logic                 hys_a;
   logic                 hys_b;
   logic                 timer_gate;
   logic                 timer_inc;
   logic                 gate_level;
   logic [15:0]          count_r;
   logic [7:0]           d;
   logic [7:0]           w;
   int                   errors;
   int                   n_compared;

   cmp_timer_gate_ctrl i_cmp_timer_gate_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .cmp_a_result(cmp_a_result), .cmp_b_result(cmp_b_result),
      .ext_gate_pin(ext_gate_pin), .timer_on(timer_on), .timer_gate_en(timer_gate_en),
      .prescale_sel(prescale_sel), .cmp_a_hysteresis_en(hys_a), .cmp_b_hysteresis_en(hys_b),
      .timer_gate(timer_gate), .timer_inc(timer_inc), .cmp_b_gate_level(gate_level));

   timer_model i_timer_model (.clk(clk), .rst_n(rst_n), .timer_inc(timer_inc), .on_req(on_req),
      .gate_en_req(gen_req), .sel_req(sel_req), .timer_on(timer_on), .timer_gate_en(timer_gate_en),
      .prescale_sel(prescale_sel), .count_r(count_r));

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts every comparison and reports a difference at once.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe beside address and data.
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // One-cycle read strobe; the data stand only in the following cycle.
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask

   // The timer may count when it runs and either gating is off or the chosen source is high.
   function automatic logic gate_ok(logic on, logic ge, logic gs, logic pin, logic cb);
      return on && (!ge || (gs ? pin : cb));
   endfunction

   // Sets up the timer path, lets it settle, then counts increments over 64 cycles.
   task automatic run_timer(input logic alt, input logic [1:0] s, input logic gs, input logic sy,
                            input logic pin, input logic cb, input logic on, input logic ge);
      logic [15:0] c0;
      int          per;
      per = (alt ? 1 : 4) << s;
      wr_reg(CTRL_OFFSET, {3'h0, alt, 2'h0, gs, sy});
      ext_gate_pin <= pin;
      cmp_b_result <= cb;
      on_req       <= on;
      gen_req      <= ge;
      sel_req      <= s;
      repeat (40) @(posedge clk);
      @(negedge clk);
      c0 = count_r;
      chk(16'(timer_gate), 16'(gs ? pin : cb));
      chk(16'(gate_level), 16'(cb));
      repeat (64) @(negedge clk);
      chk(count_r - c0, gate_ok(on, ge, gs, pin, cb) ? 16'(64 / per) : 16'h0000);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence: register checks first, then the timer path corners and random setups.
   initial begin
      rst_n = 1'b0; addr = '0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      cmp_a_result = 1'b0; cmp_b_result = 1'b0; ext_gate_pin = 1'b0;
      on_req = 1'b0; gen_req = 1'b0; sel_req = 2'h0;
      errors = 0; n_compared = 0;
      void'($urandom(85));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(CTRL_OFFSET, d);
      chk(16'(d), 16'(CTRL_RESET));
      for (int i = 0; i < 10; i++) begin
         w = (i == 0) ? 8'hFF : 8'($urandom);
         @(posedge clk);
         cmp_a_result <= 1'($urandom);
         cmp_b_result <= 1'($urandom);
         wr_reg(CTRL_OFFSET, w);
         wr_reg(4'h5, ~w);
         repeat (3) @(posedge clk);
         rd_reg(CTRL_OFFSET, d);
         chk(16'(d), 16'({cmp_a_result, cmp_b_result, 1'b0, w[4:0]}));
         rd_reg(CTRL_OFFSET, d);
         chk(16'(d), 16'({cmp_a_result, cmp_b_result, 1'b0, w[4:0]}));
         chk(16'({hys_a, hys_b}), 16'(w[3:2]));
         rd_reg(4'h5, d);
         chk(16'(d), 16'h0000);
      end
      for (int i = 0; i < 8; i++) begin
         run_timer(1'(i / 4), 2'(i % 4), 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      end
      run_timer(1'b1, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      run_timer(1'b0, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      run_timer(1'b1, 2'h0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
      run_timer(1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      run_timer(1'b1, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
      run_timer(1'b0, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      for (int i = 0; i < 6; i++) begin
         run_timer(1'($urandom), 2'($urandom), 1'($urandom), 1'b1, 1'($urandom), 1'($urandom), 1'($urandom),
                   1'($urandom));
      end
      give_verdict();
   end

   // Cuts a hang short well beyond the expected length of the run.
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      give_verdict();
   end
endmodule
